/* inc/clock_status_modulation_consts.vh */
// Register offsets, field positions and reset values of the clock, status and modulation register slice
`ifndef CLOCK_STATUS_MODULATION_CONSTS_VH
`define CLOCK_STATUS_MODULATION_CONSTS_VH

// Register offsets
`define CLOCK_CONNECT_REG_ADDR 8'h18
`define DEVICE_READINESS_STATUS_ADDR 8'h19
`define FSK_DEVIATION_SETTING_ADDR 8'h1A
`define SOFT_FSK_RAMP_SETTING_ADDR 8'h1B
`define POWER_MODULATION_SET_ZERO_ADDR 8'h1C

// Reset values
`define CLOCK_CONNECT_REG_RESET 8'h04
`define FSK_DEVIATION_SETTING_RESET 8'h00
`define SOFT_FSK_RAMP_SETTING_RESET 8'h00
`define POWER_MODULATION_SET_ZERO_RESET 8'h9F

// Clock connection fields
`define PORT_CLOCK_SELECT_MSB 4
`define PORT_CLOCK_SELECT_LSB 2
`define EXT_CLOCK_BUFFER_ON_BIT 1
`define CRYSTAL_OSC_OFF_BIT 0

// Port clock selector codes
`define PORT_CLK_REF 3'h0
`define PORT_CLK_REF_DIV2 3'h1
`define PORT_CLK_REF_DIV4 3'h2
`define PORT_CLK_REF_DIV8 3'h3
`define PORT_CLK_CHIP_X4 3'h4
`define PORT_CLK_CHIP_X2 3'h5
`define PORT_CLK_CHIP 3'h6
`define PORT_CLK_BIT 3'h7

// Readiness status fields
`define AMPLIFIER_ACTIVE_BIT 6
`define AMP_SUPPLY_OK_BIT 5
`define SYNTH_SUPPLY_OK_BIT 4
`define RECEIVE_PREPARED_BIT 3
`define TRANSMIT_PREPARED_BIT 2
`define SYNTH_LOCKED_BIT 1
`define REF_CLOCK_OK_BIT 0

// Deviation and ramp fields
`define DEVIATION_EXP_MSB 7
`define DEVIATION_EXP_LSB 5
`define DEVIATION_MANT_MSB 4
`define DEVIATION_MANT_LSB 0
`define RAMP_EXP_MSB 6
`define RAMP_EXP_LSB 4
`define RAMP_MANT_MSB 3
`define RAMP_MANT_LSB 0

// Power set zero fields
`define AMPLITUDE_KEYING_SEL_ZERO_BIT 7
`define POWER_WORD_MSB_BIT 5
`define POWER_HIGH_ZERO_MSB 4
`define POWER_HIGH_ZERO_LSB 0

// Writable bit masks, reserved bits read zero
`define CLOCK_CONNECT_REG_MASK 8'h1F
`define SOFT_FSK_RAMP_SETTING_MASK 8'h7F
`define POWER_MODULATION_SET_ZERO_MASK 8'hBF

`endif

/* hw/rate_tick.v */
// Enable pulse generator that fires once every DIVIDE clock cycles
`timescale 1ns/100ps
module rate_tick #(
   parameter DIVIDE = 2,
   parameter WIDTH = 8
) (
   ref_clk,
   reset,
   tick
);
   input wire ref_clk;
   input wire reset;
   output reg tick;

   reg [WIDTH-1:0] count_q;

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         count_q <= {WIDTH{1'b0}};
         tick <= 1'b0;
      end else if (count_q == DIVIDE[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
         count_q <= {WIDTH{1'b0}};
         tick <= 1'b1;
      end else begin
         count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
         tick <= 1'b0;
      end
   end
endmodule // rate_tick

/* hw/clock_status_modulation_regs.v */
// Clock connection, readiness status, FSK deviation/ramp and power set zero registers
`timescale 1ns/100ps
`include "clock_status_modulation_consts.vh"

module clock_status_modulation_regs #(
   parameter CHIP_DIVIDE = 8,
   parameter DIV_WIDTH = 8
) (
   input wire ref_clk,
   input wire reset,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire bit_clock_tick,
   output reg port_clock,
   input wire xo_stable,
   input wire ext_clock_present,
   output reg crystal_osc_enable,
   output reg ext_clock_buffer_enable,
   output reg digital_ref_enable,
   input wire tx_command_start,
   input wire tx_terminate,
   input wire ramp_down_engaged,
   input wire ramp_down_done,
   input wire amp_regulator_ok,
   input wire osc_regulator_ok,
   input wire loop_regulator_ok,
   input wire receive_prep_done,
   input wire transmit_prep_done,
   input wire vco_running,
   input wire pll_locked,
   output reg [2:0] deviation_exponent,
   output reg [4:0] deviation_mantissa,
   output reg freq_modulation_enable,
   output reg [2:0] ramp_exponent,
   output reg [3:0] ramp_mantissa,
   output reg freq_ramp_enable,
   input wire tx_set_flag,
   input wire tx_data_value,
   input wire amp_linear_step_test,
   input wire [4:0] amplitude_low_power,
   output reg amplitude_keying_mode,
   output reg [5:0] power_control_word,
   output reg power_word_valid
);

   localparam [1:0] AMP_IDLE = 2'b00;
   localparam [1:0] AMP_ON = 2'b01;
   localparam [1:0] AMP_RAMP = 2'b10;

   reg [7:0] clock_connect_q;
   reg [7:0] deviation_q;
   reg [7:0] ramp_q;
   reg [7:0] set_zero_q;
   reg [1:0] amp_state_q;
   reg [1:0] amp_state_d;
   reg [7:0] status_q;
   reg [7:0] status_d;
   reg [2:0] ref_div_q;
   reg port_tick;
   reg [7:0] rdata_d;

   wire chip_tick;
   wire chip_x2_tick;
   wire chip_x4_tick;
   wire [2:0] port_sel;
   wire ext_on;
   wire xo_off;

   assign port_sel = clock_connect_q[`PORT_CLOCK_SELECT_MSB:`PORT_CLOCK_SELECT_LSB];
   assign ext_on = clock_connect_q[`EXT_CLOCK_BUFFER_ON_BIT];
   assign xo_off = clock_connect_q[`CRYSTAL_OSC_OFF_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         clock_connect_q <= `CLOCK_CONNECT_REG_RESET;
         deviation_q <= `FSK_DEVIATION_SETTING_RESET;
         ramp_q <= `SOFT_FSK_RAMP_SETTING_RESET;
         set_zero_q <= `POWER_MODULATION_SET_ZERO_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `CLOCK_CONNECT_REG_ADDR: clock_connect_q <= reg_wdata & `CLOCK_CONNECT_REG_MASK;
            `FSK_DEVIATION_SETTING_ADDR: deviation_q <= reg_wdata;
            `SOFT_FSK_RAMP_SETTING_ADDR: ramp_q <= reg_wdata & `SOFT_FSK_RAMP_SETTING_MASK;
            `POWER_MODULATION_SET_ZERO_ADDR: set_zero_q <= reg_wdata & `POWER_MODULATION_SET_ZERO_MASK;
            // Status register and unmapped offsets ignore writes
            default: clock_connect_q <= clock_connect_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads, data registered one cycle after the read strobe

   always @* begin
      case (reg_addr)
         `CLOCK_CONNECT_REG_ADDR: rdata_d = clock_connect_q;
         `DEVICE_READINESS_STATUS_ADDR: rdata_d = {1'b0, status_q[6:0]};
         `FSK_DEVIATION_SETTING_ADDR: rdata_d = deviation_q;
         `SOFT_FSK_RAMP_SETTING_ADDR: rdata_d = ramp_q;
         `POWER_MODULATION_SET_ZERO_ADDR: rdata_d = set_zero_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port pin clock
   // Chip clock is an enable rate derived from ref_clk; the pin toggles on the selected enable,
   // so the pin frequency is half the enable rate. The full reference rate cannot be shown on a
   // flop-driven pin, so code 000 shows the fastest toggle the clock allows.

   rate_tick #(
      .DIVIDE(CHIP_DIVIDE),
      .WIDTH(DIV_WIDTH)
   ) chip_rate (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(chip_tick)
   );

   rate_tick #(
      .DIVIDE(CHIP_DIVIDE / 2),
      .WIDTH(DIV_WIDTH)
   ) chip_x2_rate (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(chip_x2_tick)
   );

   rate_tick #(
      .DIVIDE(CHIP_DIVIDE / 4),
      .WIDTH(DIV_WIDTH)
   ) chip_x4_rate (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(chip_x4_tick)
   );

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ref_div_q <= 3'h0;
      end else begin
         ref_div_q <= ref_div_q + 3'h1;
      end
   end

   always @* begin
      case (port_sel)
         `PORT_CLK_REF: port_tick = 1'b1;
         `PORT_CLK_REF_DIV2: port_tick = 1'b1;
         `PORT_CLK_REF_DIV4: port_tick = ref_div_q[0];
         `PORT_CLK_REF_DIV8: port_tick = (ref_div_q[1:0] == 2'h3);
         `PORT_CLK_CHIP_X4: port_tick = chip_x4_tick;
         `PORT_CLK_CHIP_X2: port_tick = chip_x2_tick;
         `PORT_CLK_CHIP: port_tick = chip_tick;
         `PORT_CLK_BIT: port_tick = bit_clock_tick;
         default: port_tick = 1'b0;
      endcase
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         port_clock <= 1'b0;
      end else if (port_tick) begin
         port_clock <= ~port_clock;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator, external buffer and digital reference enables

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         crystal_osc_enable <= 1'b0;
         ext_clock_buffer_enable <= 1'b0;
         digital_ref_enable <= 1'b0;
      end else begin
         case ({ext_on, xo_off})
            2'b00: begin
               crystal_osc_enable <= 1'b1;
               ext_clock_buffer_enable <= 1'b0;
               digital_ref_enable <= xo_stable;
            end
            2'b01: begin
               crystal_osc_enable <= 1'b0;
               ext_clock_buffer_enable <= 1'b0;
               digital_ref_enable <= 1'b0;
            end
            2'b10: begin
               crystal_osc_enable <= 1'b1;
               ext_clock_buffer_enable <= 1'b0;
               digital_ref_enable <= 1'b1;
            end
            2'b11: begin
               crystal_osc_enable <= 1'b0;
               ext_clock_buffer_enable <= 1'b1;
               digital_ref_enable <= 1'b1;
            end
            default: begin
               crystal_osc_enable <= 1'b0;
               ext_clock_buffer_enable <= 1'b0;
               digital_ref_enable <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Amplifier activity: held through any engaged ramp-down after termination

   always @* begin
      case (amp_state_q)
         AMP_IDLE: amp_state_d = tx_command_start ? AMP_ON : AMP_IDLE;
         AMP_ON: amp_state_d = !tx_terminate ? AMP_ON : (ramp_down_engaged ? AMP_RAMP : AMP_IDLE);
         AMP_RAMP: amp_state_d = ramp_down_done ? AMP_IDLE : AMP_RAMP;
         default: amp_state_d = AMP_IDLE;
      endcase
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         amp_state_q <= AMP_IDLE;
      end else begin
         amp_state_q <= amp_state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Readiness status, sampled each cycle so a read sees a stable word

   always @* begin
      status_d = 8'h00;
      status_d[`AMPLIFIER_ACTIVE_BIT] = (amp_state_q != AMP_IDLE);
      status_d[`AMP_SUPPLY_OK_BIT] = amp_regulator_ok;
      status_d[`SYNTH_SUPPLY_OK_BIT] = osc_regulator_ok & loop_regulator_ok;
      status_d[`RECEIVE_PREPARED_BIT] = receive_prep_done;
      status_d[`TRANSMIT_PREPARED_BIT] = transmit_prep_done;
      status_d[`SYNTH_LOCKED_BIT] = vco_running & pll_locked;
      // External clock counts as ready on presence alone; its stability is not judged
      status_d[`REF_CLOCK_OK_BIT] = (crystal_osc_enable & xo_stable) |
                                    (ext_clock_buffer_enable & ext_clock_present);
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         status_q <= 8'h00;
      end else begin
         status_q <= status_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Deviation and soft-FSK ramp fields

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         deviation_exponent <= 3'h0;
         deviation_mantissa <= 5'h00;
         freq_modulation_enable <= 1'b0;
         ramp_exponent <= 3'h0;
         ramp_mantissa <= 4'h0;
         freq_ramp_enable <= 1'b0;
      end else begin
         deviation_exponent <= deviation_q[`DEVIATION_EXP_MSB:`DEVIATION_EXP_LSB];
         deviation_mantissa <= deviation_q[`DEVIATION_MANT_MSB:`DEVIATION_MANT_LSB];
         freq_modulation_enable <= |deviation_q[`DEVIATION_MANT_MSB:`DEVIATION_MANT_LSB];
         ramp_exponent <= ramp_q[`RAMP_EXP_MSB:`RAMP_EXP_LSB];
         ramp_mantissa <= ramp_q[`RAMP_MANT_MSB:`RAMP_MANT_LSB];
         freq_ramp_enable <= |ramp_q[`RAMP_MANT_MSB:`RAMP_MANT_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power and modulation from set zero
   // Only set zero is held here; with flag F high the word is marked not valid so the
   // set-one logic outside can take over the amplifier.

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         amplitude_keying_mode <= 1'b0;
         power_control_word <= 6'h00;
         power_word_valid <= 1'b0;
      end else begin
         power_word_valid <= ~tx_set_flag;
         amplitude_keying_mode <= ~tx_set_flag & set_zero_q[`AMPLITUDE_KEYING_SEL_ZERO_BIT];
         if (tx_set_flag) begin
            power_control_word <= 6'h00;
         end else if (set_zero_q[`AMPLITUDE_KEYING_SEL_ZERO_BIT] & tx_data_value) begin
            power_control_word <= {1'b0, amplitude_low_power};
         end else begin
            power_control_word <= {amp_linear_step_test & set_zero_q[`POWER_WORD_MSB_BIT],
                                   set_zero_q[`POWER_HIGH_ZERO_MSB:`POWER_HIGH_ZERO_LSB]};
         end
      end
   end
endmodule // clock_status_modulation_regs

/* testbench/clock_status_modulation_regs_sva.sv */
// Concurrent checks on the clock, status and modulation register slice
`timescale 1ns/100ps
module clock_status_modulation_regs_sva (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic xo_stable,
   input wire logic crystal_osc_enable,
   input wire logic ext_clock_buffer_enable,
   input wire logic digital_ref_enable,
   input wire logic [2:0] deviation_exponent,
   input wire logic [4:0] deviation_mantissa,
   input wire logic freq_modulation_enable,
   input wire logic [2:0] ramp_exponent,
   input wire logic [3:0] ramp_mantissa,
   input wire logic freq_ramp_enable,
   input wire logic tx_set_flag,
   input wire logic amplitude_keying_mode,
   input wire logic [5:0] power_control_word,
   input wire logic power_word_valid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // A rewrite on the next edge would replace the value under test
   wire w18 = reg_wr && reg_addr == 8'h18;
   wire w1a = reg_wr && reg_addr == 8'h1A;
   wire w1b = reg_wr && reg_addr == 8'h1B;
   a_status_top_zero: assert property (reg_rd && reg_addr == 8'h19 |=> reg_rdata[7] == 1'b0)
      else $error("status bit 7 not zero");
   a_ramp_top_zero: assert property (reg_rd && reg_addr == 8'h1B |=> reg_rdata[7] == 1'b0)
      else $error("ramp bit 7 not zero");
   a_set_zero_gap: assert property (reg_rd && reg_addr == 8'h1C |=> reg_rdata[6] == 1'b0)
      else $error("set zero bit 6 not zero");
   a_xo_gated_start: assert property (w18 && reg_wdata[1:0] == 2'b00 ##1 (!w18 && !xo_stable) [*2]
      |-> crystal_osc_enable && !ext_clock_buffer_enable && !digital_ref_enable) else $error("mode 00 wrong");
   a_all_clocks_off: assert property (w18 && reg_wdata[1:0] == 2'b01 ##1 !w18
      |=> !crystal_osc_enable && !ext_clock_buffer_enable && !digital_ref_enable) else $error("mode 01 wrong");
   a_xo_ref_always: assert property (w18 && reg_wdata[1:0] == 2'b10 ##1 !w18
      |=> crystal_osc_enable && !ext_clock_buffer_enable && digital_ref_enable) else $error("mode 10 wrong");
   a_ext_buffer_mode: assert property (w18 && reg_wdata[1:0] == 2'b11 ##1 !w18
      |=> !crystal_osc_enable && ext_clock_buffer_enable && digital_ref_enable) else $error("mode 11 wrong");
   a_dev_fields: assert property (w1a ##1 !w1a |=> {deviation_exponent, deviation_mantissa} == $past(reg_wdata, 2))
      else $error("deviation fields wrong");
   a_dev_enable: assert property (freq_modulation_enable == (deviation_mantissa != 5'h00))
      else $error("modulation enable wrong");
   a_ramp_fields: assert property (w1b ##1 !w1b |=> {ramp_exponent, ramp_mantissa} == $past(reg_wdata[6:0], 2))
      else $error("ramp fields wrong");
   a_ramp_enable: assert property (freq_ramp_enable == (ramp_mantissa != 4'h0))
      else $error("ramp enable wrong");
   a_flag_set_idle: assert property (tx_set_flag
      |=> !power_word_valid && power_control_word == 6'h00 && !amplitude_keying_mode) else $error("set one drives");
   a_flag_clear_valid: assert property (!tx_set_flag |=> power_word_valid)
      else $error("set zero not valid");
endmodule // clock_status_modulation_regs_sva

bind clock_status_modulation_regs clock_status_modulation_regs_sva u_sva (.*);

/* testbench/clock_status_modulation_regs_bench.sv */
// Self-checking bench for the clock, status and modulation register slice
`timescale 1ns/100ps
module clock_status_modulation_regs_bench;
   logic ref_clk, reset, reg_wr, reg_rd, bit_clock_tick, xo_stable, ext_clock_present;
   logic [7:0] reg_addr, reg_wdata, v, st;
   logic tx_command_start, tx_terminate, ramp_down_engaged, ramp_down_done;
   logic amp_regulator_ok, osc_regulator_ok, loop_regulator_ok, receive_prep_done, transmit_prep_done;
   logic vco_running, pll_locked, tx_set_flag, tx_data_value, amp_linear_step_test;
   logic [4:0] amplitude_low_power;
   wire [7:0] reg_rdata;
   wire port_clock, crystal_osc_enable, ext_clock_buffer_enable, digital_ref_enable;
   wire [2:0] deviation_exponent, ramp_exponent;
   wire [4:0] deviation_mantissa;
   wire [3:0] ramp_mantissa;
   wire freq_modulation_enable, freq_ramp_enable, amplitude_keying_mode, power_word_valid;
   wire [5:0] power_control_word;
   int fails, checks, cycles, n, i;
   // Expected {xo, buffer, ref} per oscillator mode 11..00, with the crystal not yet stable
   logic [11:0] osc_tab = 12'b011_101_000_100;

   clock_status_modulation_regs #(.CHIP_DIVIDE(8)) u_dut (.*);

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Ceiling well above the roughly 700 cycles the tests need
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic step(input int k = 1);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask
   // Strobes end with an idle cycle so a strobe is never lowered and raised in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      step();
      reg_wr = 1'b0;
      step();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      step();
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
      step();
   endtask
   task automatic count_toggles(input int len, input int every, output int cnt);
      logic last;
      cnt = 0;
      last = port_clock;
      for (int k = 0; k < len; k++) begin
         // Last cycle leaves the tick low, so a following call never drives it twice in one step
         bit_clock_tick = (every != 0) && (k % every == 0) && (k < len - 1);
         step();
         cnt += (port_clock !== last);
         last = port_clock;
      end
   endtask
   // Crystal counts in modes 00 and 10; an external clock only behind the buffer in mode 11
   function automatic logic [7:0] exp_status(input logic [1:0] m);
      return {2'b00, amp_regulator_ok, osc_regulator_ok & loop_regulator_ok, receive_prep_done,
         transmit_prep_done, vco_running & pll_locked, (!m[0] & xo_stable) | ((m == 2'b11) & ext_clock_present)};
   endfunction
   function automatic logic [7:0] exp_power(input logic [7:0] s);
      if (tx_set_flag)
         return 8'h00;
      if (s[7] && tx_data_value)
         return {3'b110, amplitude_low_power};
      return {s[7], 1'b1, amp_linear_step_test & s[5], s[4:0]};
   endfunction

   ////////////////////////////////////////////////////////////
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, bit_clock_tick, xo_stable, ext_clock_present} = '0;
      {tx_command_start, tx_terminate, ramp_down_engaged, ramp_down_done, amplitude_low_power} = '0;
      {amp_regulator_ok, osc_regulator_ok, loop_regulator_ok, receive_prep_done, transmit_prep_done} = '0;
      {vco_running, pll_locked, tx_set_flag, tx_data_value, amp_linear_step_test} = '0;
      {fails, checks, cycles} = '0;
      reset = 1'b1;
      v = 8'($urandom(59376));
      step(3);
      reset = 1'b0;
      rd(8'h18, 8'h04);
      rd(8'h1A, 8'h00);
      rd(8'h1B, 8'h00);
      rd(8'h1C, 8'h9F);
      wr(8'h19, 8'hFF);
      rd(8'h19, 8'h00);
      wr(8'h25, 8'hFF);
      rd(8'h25, 8'h00);
      $display("test reset values done");
      for (i = 0; i < 10; i++) begin
         v = (i == 0) ? 8'hE0 : 8'($urandom);
         wr(8'h1A, v);
         chk({deviation_exponent, deviation_mantissa}, v);
         chk({7'h00, freq_modulation_enable}, {7'h00, v[4:0] != 5'h00});
         rd(8'h1A, v);
         wr(8'h1B, v);
         chk({1'b0, ramp_exponent, ramp_mantissa}, v & 8'h7F);
         chk({7'h00, freq_ramp_enable}, {7'h00, v[3:0] != 4'h0});
         rd(8'h1B, v & 8'h7F);
         wr(8'h1C, v);
         rd(8'h1C, v & 8'hBF);
      end
      $display("test register fields done");
      for (i = 0; i < 16; i++) begin
         wr(8'h18, 8'h04 | 8'(i % 4));
         st = 8'($urandom);
         {amp_regulator_ok, osc_regulator_ok, loop_regulator_ok, receive_prep_done} = st[7:4];
         {transmit_prep_done, vco_running, pll_locked, xo_stable} = st[3:0];
         ext_clock_present = 1'($urandom);
         step(2);
         rd(8'h19, exp_status(2'(i % 4)));
      end
      {amp_regulator_ok, osc_regulator_ok, loop_regulator_ok, receive_prep_done} = '0;
      {transmit_prep_done, vco_running, pll_locked, xo_stable, ext_clock_present} = '0;
      $display("test status bits done");
      tx_command_start = 1'b1;
      step();
      tx_command_start = 1'b0;
      step(2);
      rd(8'h19, 8'h40);
      ramp_down_engaged = 1'b1;
      tx_terminate = 1'b1;
      step();
      tx_terminate = 1'b0;
      step(3);
      rd(8'h19, 8'h40);
      ramp_down_done = 1'b1;
      step();
      ramp_down_done = 1'b0;
      ramp_down_engaged = 1'b0;
      step(2);
      rd(8'h19, 8'h00);
      tx_command_start = 1'b1;
      step();
      tx_command_start = 1'b0;
      tx_terminate = 1'b1;
      step();
      tx_terminate = 1'b0;
      step(2);
      rd(8'h19, 8'h00);
      $display("test amplifier status done");
      for (i = 0; i < 4; i++) begin
         wr(8'h18, 8'h18 | 8'(i));
         step();
         chk({5'h00, crystal_osc_enable, ext_clock_buffer_enable, digital_ref_enable}, 8'(osc_tab[i*3 +: 3]));
      end
      wr(8'h18, 8'h18);
      xo_stable = 1'b1;
      step(2);
      chk({5'h00, crystal_osc_enable, ext_clock_buffer_enable, digital_ref_enable}, 8'h05);
      $display("test oscillator modes done");
      wr(8'h18, 8'h1E);
      count_toggles(24, 3, n);
      chk(8'(n), 8'h08);
      count_toggles(16, 0, n);
      chk(8'(n), 8'h00);
      wr(8'h18, 8'h1A);
      count_toggles(64, 0, n);
      chk(8'(n), 8'h08);
      wr(8'h18, 8'h16);
      count_toggles(64, 0, n);
      chk(8'(n), 8'h10);
      wr(8'h18, 8'h12);
      count_toggles(64, 0, n);
      chk(8'(n), 8'h20);
      wr(8'h18, 8'h0E);
      count_toggles(64, 0, n);
      chk(8'(n), 8'h10);
      wr(8'h18, 8'h02);
      count_toggles(64, 0, n);
      chk(8'(n), 8'h40);
      $display("test port clock done");
      for (i = 0; i < 16; i++) begin
         v = 8'($urandom);
         st = 8'($urandom);
         tx_set_flag = st[0] & (i > 3);
         tx_data_value = st[1];
         amp_linear_step_test = st[2] | (i < 2);
         amplitude_low_power = st[7:3];
         wr(8'h1C, v);
         step();
         chk({amplitude_keying_mode, power_word_valid, power_control_word}, exp_power(v));
      end
      $display("test power word done");
      results();
   end
endmodule // clock_status_modulation_regs_bench
